// file: sli_blinker.sv
/*
 * sli_blinker: periodic on/off wave paced by a millisecond tick.
 * Assumes ms_tick is a one-cycle pulse synchronous to sys_clk.
 */
`timescale 1ns/1ps
module sli_blinker #(
    parameter int PERIOD_MS = 1000,         // full cycle length
    parameter int ON_MS     = 100           // lit part at start of cycle
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // timebase
    input  wire logic ms_tick,
    // wave out
    output logic      wave
);
    import sli_pkg::*;

    logic [MS_W-1:0] ms_cnt;                 // position in the cycle
    wire             at_end = (ms_cnt == MS_W'(PERIOD_MS - 1));
    wire [MS_W-1:0]  next_ms_cnt = at_end ? '0 : ms_cnt + 1'b1;

    // ------------------------------------------------------------------
    // counter and wave register
    // ------------------------------------------------------------------
    // wave is registered so the LED pins never see a decode glitch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_cnt <= '0;
            wave   <= 1'b0;
        end else if (ms_tick) begin
            ms_cnt <= next_ms_cnt;
            wave   <= (next_ms_cnt < MS_W'(ON_MS));
        end
    end

endmodule : sli_blinker

// file: sli_led_watch.sv
/* sli_led_watch: operator eye on the power indicator; counts red
   flashes per burst. Assumes the pins are sampled on sys_clk. */
`timescale 1ns/1ps
module sli_led_watch #(
    parameter int PAUSE_CYC = 1000  // dark span that closes a burst
) (
    // clock
    input  wire logic       sys_clk,
    // indicator seen
    input  wire logic       pwr_red,
    // flashes in the last complete burst
    output logic      [3:0] burst_cnt = 4'h0
);
    logic [3:0]  run_cnt = 4'h0;    // flashes in the running burst
    logic [15:0] dark    = 16'h0;   // cycles since the lamp was lit
    logic        red_q   = 1'b0;    // previous lamp level
    // a rising red level is one flash; only a long dark span ends a
    // burst, so the short gaps inside it never split the count
    always @(posedge sys_clk) begin
        red_q <= pwr_red;
        dark  <= pwr_red ? 16'h0 : dark + 16'h1;
        if (pwr_red && !red_q) begin
            run_cnt <= run_cnt + 4'h1;
        end else if (dark == 16'(PAUSE_CYC)) begin
            burst_cnt <= run_cnt;
            run_cnt   <= 4'h0;
        end
    end
endmodule : sli_led_watch

// file: sli_pkg.sv
/*
 * sli_pkg: shared constants for the status indicator block: timing,
 * register offsets, field positions, reset values and state codes.
 * Assumes a single 200 MHz system clock and a word-aligned register port.
 */
package sli_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 200;    // system clock rate
    localparam int TICK_US        = 1000;   // timebase tick, microseconds
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ; // cycles per tick
    localparam int MS_W           = 11;     // width of ms counters
    localparam int HB_PERIOD_MS   = 1000;   // heartbeat repeat
    localparam int HB_ON_MS       = 100;    // heartbeat flash length
    localparam int FL_PERIOD_MS   = 1000;   // status flash repeat
    localparam int FL_ON_MS       = 500;    // status flash lit time
    localparam int BURST_ON_MS    = 200;    // one error flash
    localparam int BURST_GAP_MS   = 300;    // dark gap between flashes
    localparam int BURST_PAUSE_MS = 1500;   // dark pause between bursts

    // ------------------------------------------------------------------
    // register port and map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_ST   = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_HIST_CNT = 8'h10;
    localparam logic [7:0] REG_HIST0    = 8'h14;  // four words follow

    // control fields
    localparam int CTRL_PWR_OFF   = 0;      // power indicator dark
    localparam int CTRL_FAULT_CLR = 1;      // write one: clear error
    localparam logic CTRL_PWR_OFF_RST = 1'h0;

    // status fields
    localparam int ST_ERR       = 0;        // error latched
    localparam int ST_CLASS_LSB = 4;        // error class, 3 bits
    localparam int ST_EVER_CONN = 8;        // first connection seen
    localparam int ST_EO_TO     = 9;        // owner timeout pending

    // interrupt bits
    localparam int IRQ_W    = 4;
    localparam int IRQ_ERR  = 0;            // error recorded
    localparam int IRQ_WD   = 1;            // watchdog fault rose
    localparam int IRQ_EOTO = 2;            // owner connection timeout
    localparam int IRQ_CONN = 3;            // connection came up
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // error history
    localparam int HIST_DEPTH = 4;
    localparam int HIST_IW    = 2;
    localparam int CODE_W     = 16;

    // error classes shown as flash counts
    localparam int CLASS_W = 3;
    localparam logic [2:0] ERR_GENERAL  = 3'h1;
    localparam logic [2:0] ERR_VOLTAGE  = 3'h2;
    localparam logic [2:0] ERR_TEMP     = 3'h3;
    localparam logic [2:0] ERR_OVERCUR  = 3'h4;
    localparam logic [2:0] ERR_CTRL     = 3'h5;
    localparam logic [2:0] ERR_WATCHDOG = 3'h6;

    // error burst sequencer
    typedef enum logic [1:0] {
        BST_IDLE  = 2'b00,
        BST_ON    = 2'b01,
        BST_GAP   = 2'b10,
        BST_PAUSE = 2'b11
    } sli_burst_t;

endpackage : sli_pkg

// file: sli_status_led.sv
/*
 * sli_status_led: drives the power, module and network indicators of a
 * motor controller from internal status flags, records error codes and
 * offers a small register port with a masked interrupt.
 * Assumes all inputs are synchronous to sys_clk; event inputs are
 * one-cycle pulses; each LED is a green/red pair driven active high.
 */
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module sli_status_led #(
    parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES // cycles per ms
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // error reports
    input  wire logic                        err_valid,
    input  wire logic [sli_pkg::CLASS_W-1:0] err_class,
    input  wire logic [sli_pkg::CODE_W-1:0]  err_detail,
    // module condition
    input  wire logic                        configured,
    input  wire logic                        minor_fault,
    input  wire logic                        wd_fault,
    // network condition
    input  wire logic                        ip_configured,
    input  wire logic                        conn_up,
    input  wire logic                        eo_timeout,
    input  wire logic                        eo_all_up,
    // register port
    input  wire logic [sli_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [sli_pkg::DATA_W-1:0]  bus_wdata,
    input  wire logic                        bus_wr,
    input  wire logic                        bus_rd,
    output logic      [sli_pkg::DATA_W-1:0]  bus_rdata,
    // interrupt
    output logic                             irq,
    // indicators
    output logic                             pwr_green,
    output logic                             pwr_red,
    output logic                             mod_green,
    output logic                             mod_red,
    output logic                             net_green,
    output logic                             net_red
);
    import sli_pkg::*;

    // ------------------------------------------------------------------
    // millisecond timebase
    // ------------------------------------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0] tick_cnt;                 // cycles inside current ms
    logic          ms_tick;                  // one pulse per ms
    wire           tick_end = (tick_cnt == TW'(TICK_CYCLES - 1));
    // free-running prescaler; all blink timing hangs off this one tick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b0;
        end else begin
            tick_cnt <= tick_end ? '0 : tick_cnt + 1'b1;
            ms_tick  <= tick_end;
        end
    end

    // ------------------------------------------------------------------
    // wave generators
    // ------------------------------------------------------------------
    logic hb_wave;                           // short heartbeat flash
    logic fl_wave;                           // even status flash
    sli_blinker #(
        .PERIOD_MS (HB_PERIOD_MS),
        .ON_MS     (HB_ON_MS)
    ) u_heartbeat (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .wave    (hb_wave)
    );
    sli_blinker #(
        .PERIOD_MS (FL_PERIOD_MS),
        .ON_MS     (FL_ON_MS)
    ) u_flash (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .wave    (fl_wave)
    );

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic                ctrl_pwr_off;       // power indicator dark
    logic [IRQ_W-1:0]    irq_st;             // sticky events
    logic [IRQ_W-1:0]    irq_mask;           // event enables
    logic                err_latched;        // an error is pending
    logic [CLASS_W-1:0]  err_class_q;        // class being flashed
    logic [CODE_W-1:0]   hist_mem [HIST_DEPTH]; // detailed codes
    logic [HIST_IW-1:0]  hist_wp;            // next history slot
    logic [7:0]          hist_cnt;           // errors seen, saturating
    logic                ever_conn;          // first connection seen
    logic                eo_lat;             // owner timeout pending
    logic                conn_q;             // conn_up last cycle
    logic                wd_q;               // wd_fault last cycle
    wire       wr_ctrl   = bus_wr && (bus_addr == REG_CTRL);
    wire       wr_irq_st = bus_wr && (bus_addr == REG_IRQ_ST);
    wire       wr_mask   = bus_wr && (bus_addr == REG_IRQ_MASK);
    wire       fault_clr = wr_ctrl && bus_wdata[CTRL_FAULT_CLR];
    wire [7:0] hist_off  = bus_addr - REG_HIST0;
    wire       hist_hit  = (hist_off[7:4] == 4'h0) &&
                           (hist_off[1:0] == 2'h0);
    wire [HIST_IW-1:0] hist_ri = hist_off[3:2];
    // status word assembled from live state
    wire [DATA_W-1:0] status_word =
        (DATA_W'(err_latched) << ST_ERR)       |
        (DATA_W'(err_class_q) << ST_CLASS_LSB) |
        (DATA_W'(ever_conn)   << ST_EVER_CONN) |
        (DATA_W'(eo_lat)      << ST_EO_TO);
    // read selection; unmapped addresses read as zero
    wire [DATA_W-1:0] next_rdata =
        (bus_addr == REG_CTRL)     ? DATA_W'(ctrl_pwr_off) :
        (bus_addr == REG_STATUS)   ? status_word :
        (bus_addr == REG_IRQ_ST)   ? DATA_W'(irq_st) :
        (bus_addr == REG_IRQ_MASK) ? DATA_W'(irq_mask) :
        (bus_addr == REG_HIST_CNT) ? DATA_W'(hist_cnt) :
        hist_hit                   ? DATA_W'(hist_mem[hist_ri]) :
                                     '0;
    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= bus_rd ? next_rdata : '0;
        end
    end
    // control and mask registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_pwr_off <= CTRL_PWR_OFF_RST;
            irq_mask     <= IRQ_MASK_RST;
        end else begin
            if (wr_ctrl) ctrl_pwr_off <= bus_wdata[CTRL_PWR_OFF];
            if (wr_mask) irq_mask     <= bus_wdata[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // error capture and history
    // ------------------------------------------------------------------
    // out-of-range classes fall back to general so a burst always ends
    wire class_ok = (err_class >= ERR_GENERAL) &&
                    (err_class <= ERR_WATCHDOG);
    wire [CLASS_W-1:0] next_class = class_ok ? err_class : ERR_GENERAL;
    // a new error in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err_latched <= 1'b0;
            err_class_q <= ERR_GENERAL;
        end else if (err_valid) begin
            err_latched <= 1'b1;
            err_class_q <= next_class;
        end else if (fault_clr) begin
            err_latched <= 1'b0;
        end
    end
    // circular history: the oldest code is overwritten when full
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hist_mem <= '{default: '0};
            hist_wp  <= '0;
            hist_cnt <= '0;
        end else if (err_valid) begin
            hist_mem[hist_wp] <= err_detail;
            hist_wp  <= hist_wp + 1'b1;
            if (hist_cnt != 8'hFF) hist_cnt <= hist_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // network state and event edges
    // ------------------------------------------------------------------
    // timeout latch: a fresh timeout beats re-establishment
    wire next_eo_lat = eo_timeout || (eo_lat && !eo_all_up);
    wire conn_rise   = conn_up && !conn_q;
    wire wd_rise     = wd_fault && !wd_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eo_lat    <= 1'b0;
            ever_conn <= 1'b0;
            conn_q    <= 1'b0;
            wd_q      <= 1'b0;
        end else begin
            eo_lat    <= next_eo_lat;
            conn_q    <= conn_up;
            wd_q      <= wd_fault;
            if (conn_up && ip_configured) ever_conn <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    wire [IRQ_W-1:0] irq_ev = {conn_rise, eo_timeout, wd_rise, err_valid};
    wire [IRQ_W-1:0] irq_clr = wr_irq_st ? bus_wdata[IRQ_W-1:0] : '0;
    // write one clears; an event in the same cycle keeps its bit set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_st <= '0;
        end else begin
            irq_st <= (irq_st & ~irq_clr) | irq_ev;
        end
    end
    assign irq = |(irq_st & irq_mask);

    // ------------------------------------------------------------------
    // error burst sequencer
    // ------------------------------------------------------------------
    sli_burst_t         burst_st;            // burst phase
    sli_burst_t         next_burst_st;
    logic [MS_W-1:0]    burst_ms;            // ms inside current phase
    logic [CLASS_W-1:0] flash_idx;           // flashes done this burst
    wire on_done    = ms_tick && (burst_ms == MS_W'(BURST_ON_MS - 1));
    wire gap_done   = ms_tick && (burst_ms == MS_W'(BURST_GAP_MS - 1));
    wire pause_done = ms_tick && (burst_ms == MS_W'(BURST_PAUSE_MS - 1));
    wire last_flash = (flash_idx + 1'b1) == err_class_q;
    // phase decode; the pause is five gaps long so bursts stand apart
    always_comb begin
        next_burst_st = burst_st;
        case (burst_st)
            BST_IDLE:  if (err_latched) next_burst_st = BST_ON;
            BST_ON:    if (on_done) begin
                next_burst_st = last_flash ? BST_PAUSE : BST_GAP;
            end
            BST_GAP:   if (gap_done) next_burst_st = BST_ON;
            BST_PAUSE: if (pause_done) next_burst_st = BST_ON;
            default:   next_burst_st = BST_IDLE;
        endcase
        // a new error restarts the burst, so a smaller class never
        // inherits a flash count already past its own number
        if (!err_latched || err_valid) next_burst_st = BST_IDLE;
    end
    // phase timer restarts on every phase change
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            burst_st  <= BST_IDLE;
            burst_ms  <= '0;
            flash_idx <= '0;
        end else begin
            burst_st <= next_burst_st;
            if (next_burst_st != burst_st) burst_ms <= '0;
            else if (ms_tick) burst_ms <= burst_ms + 1'b1;
            if (next_burst_st == BST_IDLE || burst_st == BST_PAUSE)
                flash_idx <= '0;
            else if (on_done && (burst_st == BST_ON)) // only the end of an on phase counts
                flash_idx <= flash_idx + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // indicator selection
    // ------------------------------------------------------------------
    wire pwr_lit      = !ctrl_pwr_off;
    wire next_pwr_g   = pwr_lit && !err_latched && hb_wave;
    wire next_pwr_r   = pwr_lit && err_latched &&
                        (burst_st == BST_ON);
    // module: watchdog, minor, start-up, standby, ready in that order
    wire next_mod_g = wd_fault    ? 1'b0 :
                      minor_fault ? 1'b0 :
                      !ever_conn  ? fl_wave :
                      !configured ? fl_wave :
                                    1'b1;
    wire next_mod_r = wd_fault    ? 1'b1 :
                      minor_fault ? fl_wave :
                      !ever_conn  ? !fl_wave :
                                    1'b0;
    // network: start-up alternates colours, so it reads unlike standby
    wire next_net_g = !ip_configured ? 1'b0 :
                      eo_lat         ? 1'b0 :
                      !ever_conn     ? fl_wave :
                      !conn_up       ? fl_wave :
                                       1'b1;
    wire next_net_r = !ip_configured ? 1'b0 :
                      eo_lat         ? fl_wave :
                      !ever_conn     ? !fl_wave :
                                       1'b0;
    // pins are registered so each one is a clean flip-flop output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {pwr_green, pwr_red} <= 2'h0;
            {mod_green, mod_red} <= 2'h0;
            {net_green, net_red} <= 2'h0;
        end else begin
            {pwr_green, pwr_red} <= {next_pwr_g, next_pwr_r};
            {mod_green, mod_red} <= {next_mod_g, next_mod_r};
            {net_green, net_red} <= {next_net_g, next_net_r};
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    normal_green_a: assert property (@(posedge sys_clk) disable iff (rst)
        !err_latched |=> !pwr_red)
        else $error("power red without a pending error");
    error_red_a: assert property (@(posedge sys_clk) disable iff (rst)
        err_valid |=> ##1 !pwr_green [*3])
        else $error("power green after an error");
    burst_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        (burst_st == BST_ON) |-> (flash_idx < err_class_q))
        else $error("more flashes than the error class");
    hist_store_a: assert property (@(posedge sys_clk) disable iff (rst)
        err_valid |=> (hist_mem[$past(hist_wp)] == $past(err_detail)) &&
                      (hist_wp == $past(hist_wp) + 1'b1))
        else $error("error code not stored in history");
    pwr_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_pwr_off |=> !pwr_green && !pwr_red)
        else $error("power indicator lit while switched off");
    startup_alt_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!ever_conn && !wd_fault && !minor_fault) |=> (mod_green != mod_red))
        else $error("module not alternating before connection");
    mod_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
        (configured && ever_conn && !minor_fault && !wd_fault)
        |=> mod_green && !mod_red)
        else $error("module not steady green when ready");
    mod_minor_a: assert property (@(posedge sys_clk) disable iff (rst)
        (minor_fault && !wd_fault) |=> !mod_green)
        else $error("module green during minor fault");
    mod_wd_a: assert property (@(posedge sys_clk) disable iff (rst)
        wd_fault |=> mod_red && !mod_green)
        else $error("module not steady red on watchdog");
    net_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        !ip_configured |=> !net_green && !net_red)
        else $error("network lit without an address");
    net_steady_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ip_configured && conn_up && ever_conn && !eo_lat)
        |=> net_green && !net_red)
        else $error("network not steady green when connected");
    net_timeout_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ip_configured && eo_timeout) |=> ##1 !net_green)
        else $error("network green after owner timeout");
    eo_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (eo_lat && !eo_all_up) |=> eo_lat)
        else $error("timeout cleared before owners returned");

endmodule : sli_status_led

// file: sli_status_led_dummy_guard.sv
/*
 * sli_status_led_dummy_guard: holds no logic; the indicator block is
 * the top module and its blinker helper.
 * Assumes nothing of its surroundings.
 */

// file: tb_sli_status_led.sv
/* tb_sli_status_led: self-checking bench for the indicator block.
   Assumes sli_pkg and sli_led_watch are compiled first. */
`timescale 1ns/1ps
module tb_sli_status_led;
    import sli_pkg::*;
    // ------------------------------------------------------------
    // signals, one ms tick per clock so blink times are in cycles
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0, rst = 1'b1, err_valid = 1'b0;
    logic        configured = 1'b0, minor_fault = 1'b0, wd_fault = 1'b0;
    logic        ip_configured = 1'b0, conn_up = 1'b0, eo_timeout = 1'b0;
    logic        eo_all_up = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic        rd_q = 1'b0, irq, pwr_green, pwr_red, mod_green;
    logic        mod_red, net_green, net_red;
    logic [2:0]  err_class = 3'h1;
    logic [15:0] err_detail = 16'h0, det;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, exp_q[$];
    logic [3:0]  burst_cnt;
    wire  [5:0]  leds = {pwr_green, pwr_red, mod_green, mod_red,
                         net_green, net_red};
    int          error_cnt = 0, n_checks = 0, seed = 32, hg, hr;
    sli_status_led #(.TICK_CYCLES(1)) sli_status_led_i (
        .sys_clk(sys_clk), .rst(rst), .err_valid(err_valid),
        .err_class(err_class), .err_detail(err_detail),
        .configured(configured), .minor_fault(minor_fault),
        .wd_fault(wd_fault), .ip_configured(ip_configured),
        .conn_up(conn_up), .eo_timeout(eo_timeout), .eo_all_up(eo_all_up),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .pwr_green(pwr_green), .pwr_red(pwr_red), .mod_green(mod_green),
        .mod_red(mod_red), .net_green(net_green), .net_red(net_red));
    sli_led_watch sli_led_watch_i (.sys_clk(sys_clk), .pwr_red(pwr_red),
        .burst_cnt(burst_cnt));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic results;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // the run needs about 250 us; past that something hangs
    initial begin
        #400000;
        error_cnt++;
        results();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // strobes drop with an idle cycle after, so no double drive
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        rd_q <= bus_rd;
        if (rd_q === 1'b1) begin
            chk(bus_rdata, exp_q.pop_front());
        end
    end
    // lit cycles of two lamps over one full 1000 ms blink period
    task automatic lit(input int gi, input int ri, input int eg,
                       input int er);
        hg = 0;
        hr = 0;
        repeat (3) @(posedge sys_clk);
        repeat (1000) begin
            @(posedge sys_clk);
            hg += (leds[gi] === 1'b1);
            hr += (leds[ri] === 1'b1);
        end
        chk(32'(hg), 32'(eg));
        chk(32'(hr), 32'(er));
    endtask : lit
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(REG_CTRL, 32'h0);
        rd(REG_IRQ_MASK, 32'h0);
        rd(8'h40, 32'h0);
        lit(5, 4, 100, 0);
        ip_configured <= 1'b1;
        lit(3, 2, 500, 500);
        lit(1, 0, 500, 500);
        wr(REG_IRQ_MASK, 32'h1);
        for (int c = 1; c <= 6; c++) begin
            det = 16'($random(seed));
            err_detail <= det;
            err_class  <= 3'(c);
            err_valid  <= 1'b1;
            @(posedge sys_clk);
            err_valid <= 1'b0;
            repeat (1000 * c + 3000) @(posedge sys_clk);
            chk(32'(burst_cnt), 32'(c));
            chk(32'(pwr_green), 32'h0);
            rd(REG_STATUS, 32'(c * 16 + 1));
            rd(8'(REG_HIST0 + 4 * ((c - 1) % 4)), 32'(det));
        end
        chk(32'(irq), 32'h1);
        wr(REG_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        wr(REG_IRQ_ST, 32'hF);
        rd(REG_IRQ_ST, 32'h0);
        wr(REG_CTRL, 32'h3);
        lit(5, 4, 0, 0);
        wr(REG_CTRL, 32'h0);
        {configured, ip_configured, conn_up, eo_all_up} <= 4'hF;
        repeat (4) @(posedge sys_clk);
        chk(32'(leds[3:0]), 32'hA);
        {minor_fault, wd_fault} <= 2'h3;
        lit(3, 2, 0, 1000);
        wd_fault <= 1'b0;
        lit(3, 2, 0, 500);
        {minor_fault, configured} <= 2'h0;
        lit(3, 2, 500, 0);
        {eo_timeout, eo_all_up} <= 2'h2;
        @(posedge sys_clk);
        eo_timeout <= 1'b0;
        lit(1, 0, 0, 500);
        eo_all_up <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(leds[1:0]), 32'h2);
        conn_up <= 1'b0;
        lit(1, 0, 500, 0);
        ip_configured <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(leds[1:0]), 32'h0);
        results();
    end
endmodule : tb_sli_status_led
